// ==== common/adcso_pkg.sv ====
/*
  shared constants and carriers for the conversion result serial output block.
  assumes a 24-bit result word and a host that owns select and the serial clock.
*/
package adcso_pkg;
  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 24;
  localparam int RES_BITS = 17;
  localparam int PEND_POS = 23;
  localparam int FILL_POS = 22;
  localparam int POL_POS = 21;
  localparam int RES_MSB_POS = 20;
  localparam int RES_LSB_POS = 4;
  localparam int TAIL_BITS = 4;
  localparam logic [4:0] LAST_EDGE = 5'h18;
  localparam logic [16:0] CODE_OVER = 17'h10000;
  localparam logic [16:0] CODE_UNDER = 17'h0FFFF;
  localparam logic [23:0] SHIFT_RST = 24'h000000;

  typedef enum logic [1:0] {
    ADCSO_CONV = 2'b00,
    ADCSO_SLEEP = 2'b01,
    ADCSO_OUT = 2'b11
  } adcso_state_e;

  typedef struct packed {
    logic positive;
    logic over;
    logic under;
    logic [15:0] magnitude;
  } adcso_result_s;

  typedef struct packed {
    logic oe_n;
    logic data;
  } adcso_pin_s;
endpackage

// ==== hw/adcso_top.sv ====
/*
  result word formatter and shifter for a delta-sigma converter serial port.
  assumes the host drives select_n and the serial clock (slave clock mode);
  the converter core delivers a result with a done pulse on clock_i.
*/
`timescale 1ns/1ps
// Functional notes
// - word: pending, zero, polarity, 17 result, four zeros
// - first bit high converting, low when done
// - second bit is filler, always low
// - polarity high for zero or positive input
// - over-range 11, under-range 00 in bits 21:20
// - bits 20 to 4 carry result msb first
// - bits 3 to 0 always low
// - select high: output released, clock ignored
// - pending drops at completion without clock edge
// - host samples pending on first rise; filler on first fall
// - bit 0 on 23rd fall, host latches 24th rise
// - 24th fall drives output high; new conversion once select goes high
// - out-of-range results clamp to full scale plus one lsb
// - output changes on falling edge, input sampled on rise
// - select raised mid-readout aborts, starts conversion
// - done with select high: sleep until select low
module adcso_top #(
  parameter int WORD_W = 24
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_mag_i,
  input wire logic conv_pos_i,
  input wire logic conv_over_i,
  input wire logic conv_under_i,
  input wire logic serial_clk_i,
  input wire logic select_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  output logic conv_start_o,
  output logic busy_o,
  output logic [15:0] cfg_word_o
);
  // ---------------------------------------------------------------
  // reset release and pin synchronisers (system domain)
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  function automatic logic [23:0] build_word(input adcso_pkg::adcso_result_s r);
    logic [16:0] code;
    logic sign;
    // in range the top code bit is the inverse of the polarity: 1,0 or 0,1
    code = {~r.positive, r.magnitude};
    sign = r.positive;
    if (r.over) begin
      code = adcso_pkg::CODE_OVER;
      sign = 1'b1;
    end else if (r.under) begin
      code = adcso_pkg::CODE_UNDER;
      sign = 1'b0;
    end
    // over gives 1,1 on bits 21:20 and under 0,0
    build_word = {1'b0, 1'b0, sign, code, 4'h0};
  endfunction

  // ---------------------------------------------------------------
  // system domain: conversion state and result capture
  // ---------------------------------------------------------------
  typedef struct packed {
    adcso_pkg::adcso_state_e st;
    logic [23:0] word;
    logic done_tgl;
    logic [2:0] end_sync;
    logic [1:0] sel_sync;
    logic start;
    logic busy;
    logic [15:0] cfg;
    logic [2:0] cfg_sync;
  } adcso_sys_s;
  adcso_sys_s sys_r;
  adcso_sys_s sys_nxt;

  logic end_tgl_r;
  logic [15:0] cfg_shift_r;
  logic cfg_tgl_r;

  always_comb begin
    sys_nxt = sys_r;
    sys_nxt.start = 1'b0;
    sys_nxt.end_sync = {sys_r.end_sync[1:0], end_tgl_r};
    sys_nxt.sel_sync = {sys_r.sel_sync[0], select_n_i};
    sys_nxt.cfg_sync = {sys_r.cfg_sync[1:0], cfg_tgl_r};
    if (sys_r.cfg_sync[2] != sys_r.cfg_sync[1]) begin
      sys_nxt.cfg = cfg_shift_r; // stable: link idle after the toggle
    end
    case (sys_r.st)
      adcso_pkg::ADCSO_CONV: begin
        if (conv_done_i) begin
          // word captured once so readout sees a stable value
          sys_nxt.word = build_word('{conv_pos_i, conv_over_i, conv_under_i, conv_mag_i});
          sys_nxt.done_tgl = ~sys_r.done_tgl;
          sys_nxt.busy = 1'b0;
          sys_nxt.st = sys_r.sel_sync[1] ? adcso_pkg::ADCSO_SLEEP : adcso_pkg::ADCSO_OUT;
        end
      end
      adcso_pkg::ADCSO_SLEEP: begin
        if (!sys_r.sel_sync[1]) begin
          sys_nxt.st = adcso_pkg::ADCSO_OUT;
        end
      end
      adcso_pkg::ADCSO_OUT: begin
        // link reports end of readout: full word or abort
        if (sys_r.end_sync[2] != sys_r.end_sync[1]) begin
          sys_nxt.st = adcso_pkg::ADCSO_CONV;
          sys_nxt.start = 1'b1;
          sys_nxt.busy = 1'b1;
        end
      end
      default: begin
        sys_nxt.st = adcso_pkg::ADCSO_CONV;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sys_r <= '{adcso_pkg::ADCSO_CONV, adcso_pkg::SHIFT_RST, 1'b0, 3'h0, 2'h3,
                 1'b0, 1'b1, 16'h0000, 3'h0};
    end else if (clk_en_i) begin
      sys_r <= sys_nxt;
    end
  end

  // ---------------------------------------------------------------
  // link domain: serial clock edges, select is the frame signal
  // ---------------------------------------------------------------
  // the edge counter resets on select high, so an abort needs no clock
  logic [4:0] rise_cnt_r;
  logic [23:0] shift_r;
  logic [4:0] fall_cnt_r;
  logic frame_done_r;

  always_ff @(posedge serial_clk_i or posedge select_n_i) begin
    if (select_n_i) begin
      rise_cnt_r <= 5'h00;
    end else if (rise_cnt_r != adcso_pkg::LAST_EDGE) begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end

  // no reset needed: these bits reach cfg_word_o only after 16 rises
  always_ff @(posedge serial_clk_i) begin
    if (!select_n_i && rise_cnt_r < 5'h10) begin
      cfg_shift_r <= {cfg_shift_r[14:0], serial_in_i};
    end
  end

  // word taken at the first fall; it cannot move while the output state lasts
  always_ff @(negedge serial_clk_i or posedge select_n_i) begin
    if (select_n_i) begin
      fall_cnt_r <= 5'h00;
      shift_r <= adcso_pkg::SHIFT_RST;
      frame_done_r <= 1'b0;
    end else begin
      fall_cnt_r <= rise_cnt_r;
      if (rise_cnt_r == 5'h01) begin
        shift_r <= {sys_r.word[22:0], 1'b0};
      end else if (rise_cnt_r != 5'h00 && rise_cnt_r < adcso_pkg::LAST_EDGE) begin
        shift_r <= {shift_r[22:0], 1'b0};
      end
      if (rise_cnt_r == adcso_pkg::LAST_EDGE) begin
        frame_done_r <= 1'b1;
      end
    end
  end

  // frame end: select raised after at least one rise, after the 24th fall or mid-readout
  always_ff @(posedge select_n_i or negedge rst_n) begin
    if (!rst_n) begin
      end_tgl_r <= 1'b0;
      cfg_tgl_r <= 1'b0;
    end else begin
      if (rise_cnt_r != 5'h00 || frame_done_r) begin
        end_tgl_r <= ~end_tgl_r;
      end
      if (rise_cnt_r >= 5'h10) begin
        cfg_tgl_r <= ~cfg_tgl_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drive: pending level follows state live, no clock needed
  // ---------------------------------------------------------------
  // link bits cross through two flops; serial clock is slow enough for this
  logic [2:0] lnk_meta_r;
  logic [2:0] lnk_sync_r;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lnk_meta_r <= 3'h0;
      lnk_sync_r <= 3'h0;
    end else if (clk_en_i) begin
      lnk_meta_r <= {frame_done_r, fall_cnt_r != 5'h00, shift_r[adcso_pkg::PEND_POS]};
      lnk_sync_r <= lnk_meta_r;
    end
  end

  adcso_pkg::adcso_pin_s pin_r;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= '{1'b1, 1'b1};
    end else if (clk_en_i) begin
      pin_r.oe_n <= sys_r.sel_sync[1];
      if (lnk_sync_r[2]) begin
        pin_r.data <= 1'b1;
      end else if (!lnk_sync_r[1]) begin
        pin_r.data <= sys_r.busy;
      end else begin
        pin_r.data <= lnk_sync_r[0];
      end
    end
  end

  assign serial_out_o = pin_r.data;
  assign serial_out_oe_n_o = pin_r.oe_n;
  assign conv_start_o = sys_r.start;
  assign busy_o = sys_r.busy;
  assign cfg_word_o = sys_r.cfg;
endmodule

// ==== test/adcso_chk.sv ====
/* port checker for adcso_top.
   assumes a bind onto adcso_top; all checks on clock_i. */
`timescale 1ns/1ps
module adcso_chk (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic select_n_i,
  input wire logic conv_done_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_n_o,
  input wire logic conv_start_o,
  input wire logic busy_o,
  input wire logic [15:0] cfg_word_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // six cycles cover the select synchroniser plus output register
  sequence s_hi; select_n_i [*6]; endsequence
  sequence s_lo; !select_n_i [*6]; endsequence
  property p_rel; s_hi |-> serial_out_oe_n_o; endproperty
  a_rel: assert property (p_rel) else $error("output driven while deselected");
  property p_drv; s_lo |-> !serial_out_oe_n_o; endproperty
  a_drv: assert property (p_drv) else $error("output not driven while selected");
  property p_pend; (busy_o && !select_n_i && !conv_done_i) [*6] |-> serial_out_o; endproperty
  a_pend: assert property (p_pend) else $error("pending flag low while busy");
  property p_eoc; s_lo ##0 (conv_done_i && busy_o) |-> ##[1:4] !serial_out_o; endproperty
  a_eoc: assert property (p_eoc) else $error("no completion edge on output");
  property p_start; conv_start_o |-> ##[0:2] busy_o; endproperty
  a_start: assert property (p_start) else $error("start without busy");
  property p_sleep; (select_n_i && !busy_o) [*6] |=> !conv_start_o; endproperty
  a_sleep: assert property (p_sleep) else $error("conversion left sleep");
  property p_done; conv_done_i && busy_o && clk_en_i |-> ##[1:3] !busy_o; endproperty
  a_done: assert property (p_done) else $error("busy held after done");
  property p_cfg; s_hi |=> $stable(cfg_word_o); endproperty
  a_cfg: assert property (p_cfg) else $error("config moved while deselected");
endmodule
bind adcso_top adcso_chk chk (.clock_i, .rst_n_i, .clk_en_i, .select_n_i, .conv_done_i,
  .serial_out_o,
  .serial_out_oe_n_o, .conv_start_o, .busy_o, .cfg_word_o);

// ==== test/adcso_host.sv ====
/* host model: drives select, serial clock and config bits, collects the word.
   assumes a free 32 ns link clock; serial clock is link clock / 8, frames only. */
`timescale 1ns/1ps
module adcso_host (
  input wire logic link_clk_i,
  input wire logic sdo_i,
  output logic select_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  initial begin
    select_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic sel(input logic v);
    @(posedge link_clk_i);
    select_n_o <= v;
    sdi_o <= ~sdi_o;
    repeat (8) @(posedge link_clk_i);
  endtask
  // serial clock kept well below clock_i / 4 so the sync can follow it
  task automatic shift(input int n, input logic [15:0] cfg, output logic [23:0] w);
    w = 24'h000000;
    for (int i = 0; i < n; i++) begin
      sdi_o <= (i < 16) ? cfg[15 - i] : 1'b0;
      repeat (4) @(posedge link_clk_i);
      w = {w[22:0], sdo_i};
      sclk_o <= 1'b1;
      repeat (4) @(posedge link_clk_i);
      sclk_o <= 1'b0;
    end
  endtask
endmodule

// ==== test/adcso_top_bench.sv ====
/* bench for adcso_top: converter core modelled by done pulses, host on a link clock.
   assumes adcso_host and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module adcso_top_bench;
  logic clock_i = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic done = 1'b0;
  logic clk_en = 1'b1;
  logic [18:0] res = 19'h00000;
  logic sclk, sel_n, serial_in, serial_out, oe_n, start, busy;
  logic [15:0] cfg;
  logic [23:0] w, e;
  int n_errors = 0;
  int checked = 0;
  logic [18:0] cases [4] = '{19'h61234, 19'h10000, 19'h4FFFF, 19'h08001};
  always #12.5 clock_i = ~clock_i;
  always #16 link_clk = ~link_clk;
  adcso_top dut (.clock_i, .rst_n_i(rst_n), .clk_en_i(clk_en), .conv_done_i(done),
    .conv_mag_i(res[15:0]), .conv_pos_i(res[18]), .conv_over_i(res[17]),
    .conv_under_i(res[16]), .serial_clk_i(sclk), .select_n_i(sel_n), .serial_in_i(serial_in),
    .serial_out_o(serial_out), .serial_out_oe_n_o(oe_n), .conv_start_o(start), .busy_o(busy),
    .cfg_word_o(cfg));
  adcso_host host (.link_clk_i(link_clk), .sdo_i(oe_n ? ~serial_out : serial_out), .select_n_o(sel_n),
    .sclk_o(sclk), .sdi_o(serial_in));
  task automatic clk(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic convert(input logic [18:0] r);
    @(posedge clock_i);
    res <= r;
    done <= 1'b1;
    @(posedge clock_i);
    done <= 1'b0;
    clk(4);
  endtask
  task automatic wait_start;
    int k;
    k = 0;
    while (start !== 1'b1 && k < 40) begin
      clk(1);
      k++;
    end
    `CHK("conv_start", 1'b1, start)
  endtask
  // r is {positive, over, under, magnitude}
  function automatic logic [23:0] word(input logic [18:0] r);
    logic [16:0] c;
    c = r[17] ? adcso_pkg::CODE_OVER : r[16] ? adcso_pkg::CODE_UNDER : {~r[18], r[15:0]};
    return {2'b00, r[17] | (r[18] & ~r[16]), c, 4'h0};
  endfunction
  task automatic results;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    results;
  end
  initial begin
    repeat (6) @(posedge clock_i);
    rst_n <= 1'b1;
    clk(6);
    `CHK("oe_n idle", 1'b1, oe_n)
    host.sel(1'b0);
    `CHK("pending", 1'b1, serial_out)
    convert(19'h4A5C3);
    `CHK("eoc", 1'b0, serial_out)
    host.shift(24, 16'h5A3C, w);
    clk(4);
    `CHK("next pending", 1'b1, serial_out)
    fork
      host.sel(1'b1);
      wait_start;
    join
    `CHK("word", word(19'h4A5C3), w)
    `CHK("cfg", 16'h5A3C, cfg)
    $display("test status and first word done");
    for (int i = 0; i < 4; i++) begin
      convert(cases[i]);
      clk(20);
      `CHK("sleep busy", 1'b0, busy)
      host.sel(1'b0);
      host.shift(24, 16'h0000, w);
      fork
        host.sel(1'b1);
        wait_start;
      join
      if (i == 3) `CHK("neg head", 4'h1, w[23:20])
      else `CHK("word", word(cases[i]), w)
    end
    $display("test range codes done");
    convert(19'h40F0F);
    e = word(19'h40F0F);
    host.sel(1'b0);
    host.shift(10, 16'hFFFF, w);
    fork
      host.sel(1'b1);
      wait_start;
    join
    `CHK("partial", e[23:14], w[9:0])
    `CHK("cfg hold", 16'h0000, cfg)
    $display("test abort done");
    @(posedge clock_i);
    clk_en <= 1'b0;
    convert(19'h4A5C3);
    `CHK("frozen busy", 1'b1, busy)
    @(posedge clock_i);
    clk_en <= 1'b1;
    $display("test clock enable done");
    results;
  end
endmodule
